/* sepf_framing.sv */
// Pin-level serial framing of a small serial EEPROM, device side
`timescale 1ns/1ps
module sepf_framing
  import sepf_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_TIME_CYC
)(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  // Serial pins from the master
  input  wire logic                chip_select,
  input  wire logic                serial_clock,
  input  wire logic                serial_in,
  // Serial output pin, enable active low
  output logic                     serial_out,
  output logic                     serial_out_en_n,
  // Array read port
  output logic [ADDR_W-1:0]        array_addr,
  input  wire logic [DATA_W-1:0]   array_rdata,
  // Array programming request
  output logic                     prog_start,
  output logic                     prog_all,
  output logic                     prog_erase,
  output logic [DATA_W-1:0]        prog_data,
  output logic                     busy
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0]          cs_sync;
    logic [2:0]          sk_sync;
    logic [2:0]          di_sync;
    sepf_state_t         state;
    logic [4:0]          cnt;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   shreg;
    sepf_act_t           act;
    logic                wr_en;
    logic                cs_hold;
    logic                sk_hold;
    logic [3:0]          desel_cnt;
    logic [23:0]         prog_cnt;
    logic                busy;
    logic                sout;
    logic                prog_start;
    logic                prog_all;
    logic                prog_erase;
    logic [DATA_W-1:0]   prog_data;
  } sepf_regs_t;

  sepf_regs_t r_reg;
  sepf_regs_t r_next;

  ////////////////////////////////////////////////////////////////////////
  // Filtered select and clock levels: second and third stages agree; data is the third stage
  logic cs_hold;
  logic sk_hold;
  logic sk_rise;
  logic di_lvl;
  logic cs_rise;
  logic cs_fall;
  logic cs_stable;
  logic sk_stable;

  // Accepted levels live in the state struct
  assign cs_hold   = r_reg.cs_hold;
  assign sk_hold   = r_reg.sk_hold;
  assign cs_stable = r_reg.cs_sync[1] == r_reg.cs_sync[2];
  assign sk_stable = r_reg.sk_sync[1] == r_reg.sk_sync[2];
  assign cs_rise   = r_reg.cs_sync[1] & r_reg.cs_sync[2] & ~cs_hold;
  assign cs_fall   = ~r_reg.cs_sync[1] & ~r_reg.cs_sync[2] & cs_hold;
  assign sk_rise   = r_reg.sk_sync[1] & r_reg.sk_sync[2] & ~sk_hold;
  assign di_lvl    = r_reg.di_sync[2];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    r_next            = r_reg;
    r_next.cs_sync    = {r_reg.cs_sync[1:0], chip_select};
    r_next.sk_sync    = {r_reg.sk_sync[1:0], serial_clock};
    r_next.di_sync    = {r_reg.di_sync[1:0], serial_in};
    r_next.prog_start = 1'b0;

    // Accepted levels follow the pins once two stages agree
    if (cs_stable)
      r_next.cs_hold = r_reg.cs_sync[2];
    if (sk_stable)
      r_next.sk_hold = r_reg.sk_sync[2];

    // Self-timed programming countdown
    if (r_reg.busy)
    begin
      if (r_reg.prog_cnt == 24'h00_0000)
        r_next.busy = 1'b0;
      else
        r_next.prog_cnt = r_reg.prog_cnt - 24'h00_0001;
    end

    // Deselect timer clears registers after the minimum low time
    if (!cs_hold)
    begin
      if (r_reg.desel_cnt != MIN_DESELECT_CYC[3:0])
        r_next.desel_cnt = r_reg.desel_cnt + 4'h1;
      else
      begin
        r_next.state    = ST_IDLE;
        r_next.shreg    = '0;
        r_next.cnt      = '0;
      end
    end
    else
      r_next.desel_cnt = '0;

    // Select rising: fresh cycle
    if (cs_rise)
    begin
      r_next.state = ST_IDLE;
      r_next.cnt   = '0;
      r_next.act   = ACT_NONE;
      r_next.sout  = ~r_reg.busy;
    end

    // Select falling: launch the decoded action
    if (cs_fall)
    begin
      case (r_reg.act)
        ACT_ENABLE:  r_next.wr_en = 1'b1;
        ACT_DISABLE: r_next.wr_en = 1'b0;
        ACT_WRITE, ACT_PROGALL, ACT_ERASE, ACT_ERALL:
        begin
          if (r_reg.wr_en && !r_reg.busy)
          begin
            r_next.prog_start = 1'b1;
            r_next.busy       = 1'b1;
            r_next.prog_cnt   = 24'(PROG_CYCLES - 1);
            r_next.prog_all   = (r_reg.act == ACT_PROGALL) || (r_reg.act == ACT_ERALL);
            r_next.prog_erase = (r_reg.act == ACT_ERASE) || (r_reg.act == ACT_ERALL);
            r_next.prog_data  = r_reg.shreg;
          end
        end
        default: ;
      endcase
      r_next.act = ACT_NONE;
    end

    // Serial bit handling, only while selected
    if (cs_hold && sk_rise && !r_reg.busy)
    begin
      case (r_reg.state)
        ST_IDLE:
        begin
          if (di_lvl)
          begin
            r_next.state = ST_HDR;
            r_next.cnt   = '0;
          end
        end
        ST_HDR:
        begin
          r_next.shreg = {r_reg.shreg[DATA_W-2:0], di_lvl};
          r_next.cnt   = r_reg.cnt + 5'h1;
          if (r_reg.cnt == HDR_LAST)
          begin
            r_next.addr = {r_reg.shreg[ADDR_W-2:0], di_lvl};
            r_next.cnt  = '0;
            case (r_reg.shreg[ADDR_W:ADDR_W-1])
              OPC_READ:
              begin
                r_next.state = ST_READ;
                r_next.sout  = 1'b0;
              end
              OPC_WRITE:
              begin
                r_next.state = ST_DATA;
                r_next.act   = ACT_WRITE;
              end
              OPC_ERASE:
              begin
                r_next.state = ST_DONE;
                r_next.act   = ACT_ERASE;
              end
              default:
              begin
                case (r_reg.shreg[ADDR_W-2:ADDR_W-3])
                  EXT_PROGALL:
                  begin
                    r_next.state = ST_DATA;
                    r_next.act   = ACT_PROGALL;
                  end
                  EXT_ERALL:   r_next.act = ACT_ERALL;
                  EXT_ENABLE:  r_next.act = ACT_ENABLE;
                  default:     r_next.act = ACT_DISABLE;
                endcase
                if (r_reg.shreg[ADDR_W-2:ADDR_W-3] != EXT_PROGALL)
                  r_next.state = ST_DONE;
              end
            endcase
          end
        end
        ST_DATA:
        begin
          r_next.shreg = {r_reg.shreg[DATA_W-2:0], di_lvl};
          r_next.cnt   = r_reg.cnt + 5'h1;
          if (r_reg.cnt == DATA_LAST)
            r_next.state = ST_ARMED;
        end
        ST_READ:
        begin
          // First rise loads the word; later rises shift
          if (r_reg.cnt == 5'h0)
          begin
            r_next.sout  = array_rdata[DATA_W-1];
            r_next.shreg = {array_rdata[DATA_W-2:0], 1'b0};
          end
          else
          begin
            r_next.sout  = r_reg.shreg[DATA_W-1];
            r_next.shreg = {r_reg.shreg[DATA_W-2:0], 1'b0};
          end
          if (r_reg.cnt != DATA_LAST + 5'h1)
            r_next.cnt = r_reg.cnt + 5'h1;
        end
        ST_ARMED:
        begin
          // Extra clock after the last data bit cancels the write
          r_next.act   = ACT_NONE;
          r_next.state = ST_DONE;
        end
        default: ;
      endcase
    end

    // Status shown on output while selected and programming
    if (cs_hold && (r_reg.busy || r_reg.state == ST_IDLE) && !cs_rise)
      r_next.sout = ~r_next.busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r_reg         <= '0;
      r_reg.state   <= ST_IDLE;
      r_reg.act     <= ACT_NONE;
      r_reg.cs_sync <= SYNC_RST;
      r_reg.sout    <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign serial_out      = r_reg.sout;
  assign serial_out_en_n = ~cs_hold;
  assign array_addr      = r_reg.addr;
  assign prog_start      = r_reg.prog_start;
  assign prog_all        = r_reg.prog_all;
  assign prog_erase      = r_reg.prog_erase;
  assign prog_data       = r_reg.prog_data;
  assign busy            = r_reg.busy;

endmodule : sepf_framing

/* sepf_pkg.sv */
// Constants and types for the serial EEPROM pin framing block
// What this block does
// - Select high means selected; communication happens only while select is high.
// - Rising select edge resets the command state machine for a new cycle.
// - Select falling after a complete write-type command starts self-timed programming.
// - While deselected, serial clock and input are ignored; output takes no part.
// - Every input bit is sampled on the serial clock rising edge while selected.
// - Output data changes after each serial clock rising edge.
// - Output driven only while selected, released when deselected.
// - Select held low a minimum time clears the command state, shift register and bit count.
// - Cycle starts with a one start bit; leading zeros are ignored.
// - Start, 2-bit opcode, 6-bit address, 16-bit data for writes, MSB first.
// - Read outputs a dummy zero then 16 data bits, MSB first.
// - Reselected while programming, output low when busy, high when ready, no clock needed.
package sepf_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned MIN_DESELECT_NS    = 1000;
  localparam int unsigned MIN_DESELECT_CYC   =
    (MIN_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_TIME_MS       = 15;
  localparam int unsigned PROG_TIME_CYC      = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // Field widths
  localparam int unsigned OPC_W  = 2;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;

  // Bit counts within a cycle (after the start bit)
  localparam logic [4:0] HDR_LAST  = 5'h07;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  // Opcodes
  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  // Extended commands, held in address bits 5:4
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_PROGALL = 2'h1;
  localparam logic [1:0] EXT_ERALL   = 2'h2;
  localparam logic [1:0] EXT_ENABLE  = 2'h3;

  // Reset values
  localparam logic [2:0] SYNC_RST = 3'h0;

  // Command state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_DATA  = 3'b010,
    ST_READ  = 3'b011,
    ST_ARMED = 3'b100,
    ST_DONE  = 3'b101
  } sepf_state_t;

  // Pending action launched at select fall
  typedef enum logic [2:0] {
    ACT_NONE    = 3'b000,
    ACT_WRITE   = 3'b001,
    ACT_PROGALL = 3'b010,
    ACT_ERASE   = 3'b011,
    ACT_ERALL   = 3'b100,
    ACT_ENABLE  = 3'b101,
    ACT_DISABLE = 3'b110
  } sepf_act_t;

endpackage : sepf_pkg

/* sepf_framing_props.sv */
// Pin-level assertions for the serial EEPROM framing block
`timescale 1ns/1ps
module sepf_framing_props #(
  parameter int unsigned PROG_CYCLES = 20
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Watched pins
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_out,
  input wire logic serial_out_en_n,
  input wire logic prog_start,
  input wire logic busy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Busy length and ages since the last clock rise and busy
  logic [31:0] bcnt_reg;
  logic [7:0]  sk_age_reg;
  logic [7:0]  bz_age_reg;
  logic        sk_d_reg;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bcnt_reg   <= 32'h0000_0000;
      sk_age_reg <= 8'hFF;
      bz_age_reg <= 8'hFF;
      sk_d_reg   <= 1'b0;
    end
    else
    begin
      bcnt_reg   <= busy ? bcnt_reg + 32'h0000_0001 : 32'h0000_0000;
      sk_age_reg <= (serial_clock && !sk_d_reg) ? 8'h00 : sk_age_reg + {7'h00, sk_age_reg != 8'hFF};
      bz_age_reg <= busy ? 8'h00 : bz_age_reg + {7'h00, bz_age_reg != 8'hFF};
      sk_d_reg   <= serial_clock;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  en_off_a: assert property (!chip_select [*8] |-> serial_out_en_n)
    else $error("output driven while deselected");
  en_on_a: assert property (chip_select [*8] |-> !serial_out_en_n)
    else $error("output released while selected");
  start_low_a: assert property (prog_start |-> !chip_select)
    else $error("programming started while selected");
  start_pulse_a: assert property (prog_start |=> !prog_start && busy)
    else $error("start pulse or busy wrong");
  busy_len_a: assert property ($fell(busy) |-> bcnt_reg == PROG_CYCLES)
    else $error("busy length wrong");
  idle_quiet_a: assert property (!chip_select [*8] |-> !prog_start)
    else $error("start while long deselected");
  busy_lock_a: assert property ($past(busy) |-> !prog_start)
    else $error("start while busy");
  status_busy_a: assert property ((busy && chip_select) [*8] |-> !serial_out)
    else $error("status not low while busy");
  out_edge_a: assert property (chip_select && $past(serial_out_en_n, 4) == 1'b0
    && !serial_out_en_n && bz_age_reg > 8'h08 && $changed(serial_out) |-> sk_age_reg < 8'h0C)
    else $error("output changed away from clock rise");
endmodule : sepf_framing_props

bind sepf_framing sepf_framing_props #(.PROG_CYCLES(PROG_CYCLES)) u_sepf_framing_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .chip_select(chip_select),
  .serial_clock(serial_clock), .serial_out(serial_out), .serial_out_en_n(serial_out_en_n),
  .prog_start(prog_start), .busy(busy)
);

/* sepf_master.sv */
// Behavioural serial master facing the EEPROM framing block
`timescale 1ns/1ps
module sepf_master (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out
);
  logic        active;
  logic        bit_q;
  logic        idle_q;
  logic [16:0] shift_q;
  // Idle data line toggles so stale bits are never seen
  initial
  begin
    chip_select  = 1'b0;
    serial_clock = 1'b0;
    active       = 1'b0;
    bit_q        = 1'b0;
    idle_q       = 1'b0;
    shift_q      = 17'h0_0000;
  end
  always @(posedge core_clk) idle_q <= ~idle_q;
  assign serial_in = active ? bit_q : idle_q;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc
  // One bit of 800 ns: setup, rise, high 4, low, sample answer
  task automatic clk_bit(input logic b);
    bit_q <= b;
    wait_cyc(2);
    serial_clock <= 1'b1;
    wait_cyc(4);
    serial_clock <= 1'b0;
    wait_cyc(2);
    shift_q <= {shift_q[15:0], serial_out};
  endtask : clk_bit
  // Whole cycle: select, zeros, start, fields MSB first, deselect
  task automatic frame(input int zeros, input int n, input logic [23:0] bits,
                       output logic [16:0] rd);
    active <= 1'b1;
    chip_select <= 1'b1;
    wait_cyc(6);
    repeat (zeros) clk_bit(1'b0);
    clk_bit(1'b1);
    for (int i = 23; i > 23 - n; i--) clk_bit(bits[i]);
    @(posedge core_clk);
    rd = shift_q;
    chip_select <= 1'b0;
    active <= 1'b0;
    wait_cyc(12);
  endtask : frame
  // Status poll with no serial clock
  task automatic poll(output logic st);
    chip_select <= 1'b1;
    wait_cyc(12);
    st = serial_out;
    chip_select <= 1'b0;
    wait_cyc(12);
  endtask : poll
  // Clock pulses while deselected
  task automatic noise();
    repeat (3)
    begin
      serial_clock <= 1'b1;
      wait_cyc(4);
      serial_clock <= 1'b0;
      wait_cyc(4);
    end
  endtask : noise
endmodule : sepf_master

/* sepf_framing_tb.sv */
// Self-checking bench for the serial EEPROM framing block
`timescale 1ns/1ps
module sepf_framing_tb
  import sepf_pkg::*;
;
  localparam int unsigned PCYC = 60;
  logic              core_clk;
  logic              sys_rst;
  logic              chip_select;
  logic              serial_clock;
  logic              serial_in;
  logic              serial_out;
  logic              serial_out_en_n;
  logic              do_line;
  logic [ADDR_W-1:0] array_addr;
  logic [DATA_W-1:0] array_rdata;
  logic              prog_start;
  logic              prog_all;
  logic              prog_erase;
  logic [DATA_W-1:0] prog_data;
  logic              busy;
  logic [15:0]       arr [64];
  logic [15:0]       ref_mem [64];
  logic              ref_en;
  logic [5:0]        a;
  logic [15:0]       d;
  int                seed;
  int                checked;
  int                miscompares;
  int                cycles;
  int                kinds [9] = '{2, 0, 5, 0, 6, 0, 4, 1, 0};
  ////////////////////////////////////////////////////////////////////////////////
  sepf_framing #(.PROG_CYCLES(PCYC)) u_sepf_framing (
    .core_clk(core_clk), .sys_rst(sys_rst), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n), .array_addr(array_addr),
    .array_rdata(array_rdata), .prog_start(prog_start), .prog_all(prog_all),
    .prog_erase(prog_erase), .prog_data(prog_data), .busy(busy)
  );
  sepf_master u_sepf_master (
    .core_clk(core_clk), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(do_line)
  );
  // Released output line shows the inverse of the last driven value
  assign do_line = serial_out_en_n ? ~serial_out : serial_out;
  assign array_rdata = arr[array_addr];
  // Array model programs on the start pulse
  always @(posedge core_clk)
    if (prog_start)
      for (int i = 0; i < 64; i++)
        if (prog_all || i == array_addr)
          arr[i] <= prog_erase ? 16'hFFFF : prog_data;
  // Clock and hang limit
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // One command, reference update and result checks
  task automatic op(input int kind, input logic [5:0] ad, input logic [15:0] dd);
    logic [23:0] bits;
    logic [16:0] rd;
    logic        st;
    case (kind)
      0: bits = {OPC_READ, ad, 16'h0000};
      1: bits = {OPC_WRITE, ad, dd};
      2: bits = {OPC_ERASE, ad, 16'h0000};
      3: bits = {OPC_EXT, EXT_ENABLE, 4'h0, 16'h0000};
      4: bits = {OPC_EXT, EXT_DISABLE, 4'h0, 16'h0000};
      5: bits = {OPC_EXT, EXT_PROGALL, 4'h0, dd};
      default: bits = {OPC_EXT, EXT_ERALL, 4'h0, 16'h0000};
    endcase
    u_sepf_master.frame($unsigned($random(seed)) % 4, (kind < 2 || kind == 5) ? 24 : 8,
                        bits, rd);
    if (kind == 0)
      chk_word("read", {1'b0, ref_mem[ad]}, rd);
    if (kind == 1 || kind == 2 || kind > 4)
    begin
      for (int i = 0; i < 64; i++)
        if (ref_en && (kind > 4 || i == ad))
          ref_mem[i] = (kind % 2 == 0) ? 16'hFFFF : dd;
      u_sepf_master.poll(st);
      chk_bit("status", !ref_en, st);
      for (int k = 0; k < 20 && st !== 1'b1; k++)
        u_sepf_master.poll(st);
      chk_bit("ready", 1'b1, st);
    end
    if (kind == 3 || kind == 4)
      ref_en = (kind == 3);
  endtask : op
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    seed    = 32'h4e5a_81fa;
    sys_rst = 1'b1;
    ref_en  = 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      arr[i]     = 16'($random(seed));
      ref_mem[i] = arr[i];
    end
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk_bit("out_en_n", 1'b1, serial_out_en_n);
    op(1, 6'h2A, 16'h1234);
    op(0, 6'h2A, 16'h0000);
    op(3, 6'h00, 16'h0000);
    for (int j = 0; j < 6; j++)
    begin
      a = 6'($random(seed));
      d = 16'($random(seed));
      op(1, a, d);
      op(0, a, 16'h0000);
    end
    u_sepf_master.noise();
    op(0, a, 16'h0000);
    d = 16'($random(seed));
    foreach (kinds[k])
      op(kinds[k], 6'($random(seed)), d);
    end_sim();
  end
endmodule : sepf_framing_tb
